// File: core/b2ddr_defs.vh
`ifndef B2DDR_DEFS_VH
`define B2DDR_DEFS_VH
// Word and lane geometry (wide configuration)
`define B2DDR_DATA_W 36
`define B2DDR_LANE_W 9
`define B2DDR_LANES 4
// Address width counting the burst start bit
`define B2DDR_ADDR_W 19
// Address width of one internal array (address width minus the burst bit)
`define B2DDR_ARR_AW 18
// Read data FIFO depth and pointer width
`define B2DDR_FIFO_DEPTH 4
`define B2DDR_FIFO_PW 2
// Read latency in sampled clock edges before first word leaves
`define B2DDR_RD_LAT 1
`endif

// File: core/b2ddr_array.v
`timescale 1ns/1ps
`default_nettype none
// --------------------------------------------------------------
// One internal array with per-lane write enables, registered read
// --------------------------------------------------------------
module b2ddr_array #(
    parameter AW = 18,
    parameter DW = 36,
    parameter LW = 9,
    parameter LN = 4
) (
    // Clock
    input wire i_clk,
    // Write port
    input wire i_we,
    input wire [LN-1:0] i_lane_en,
    input wire [AW-1:0] i_waddr,
    input wire [DW-1:0] i_wdata,
    // Read port
    input wire i_re,
    input wire [AW-1:0] i_raddr,
    output reg [DW-1:0] o_rdata
);
    reg [DW-1:0] mem [0:(1<<AW)-1];
    integer k;
    // Lanes with a disabled enable keep their stored byte
    always @(posedge i_clk) begin
        if (i_we) begin
            for (k = 0; k < LN; k = k + 1) begin
                if (i_lane_en[k]) begin
                    mem[i_waddr][k*LW +: LW] <= i_wdata[k*LW +: LW];
                end
            end
        end
        if (i_re) begin
            o_rdata <= mem[i_raddr];
        end
    end
endmodule // b2ddr_array
`default_nettype wire

// File: core/b2ddr_fifo.v
`timescale 1ns/1ps
`default_nettype none
// --------------------------------------------------------------
// Small synchronous FIFO with valid/ready on both sides
// --------------------------------------------------------------
module b2ddr_fifo #(
    parameter DW = 36,
    parameter DEPTH = 4,
    parameter PW = 2
) (
    // Clock and reset
    input wire i_clk,
    input wire i_rst_n,
    // Fill side
    input wire i_valid,
    output wire o_ready,
    input wire [DW-1:0] i_data,
    // Drain side
    output wire o_valid,
    input wire i_ready,
    output wire [DW-1:0] o_data
);
    reg [DW-1:0] buf_mem [0:DEPTH-1];
    reg [PW-1:0] wptr;
    reg [PW-1:0] rptr;
    reg [PW:0] count;
    wire push;
    wire pop;
    // Honest full and empty from the occupancy count
    assign o_ready = (count != DEPTH[PW:0]);
    assign o_valid = (count != {(PW+1){1'b0}});
    assign o_data = buf_mem[rptr];
    assign push = i_valid & o_ready;
    assign pop = o_valid & i_ready;
    // Pointer and count update
    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            wptr <= {PW{1'b0}};
            rptr <= {PW{1'b0}};
            count <= {(PW+1){1'b0}};
        end else begin
            if (push) begin
                wptr <= wptr + 1'b1;
            end
            if (pop) begin
                rptr <= rptr + 1'b1;
            end
            if (push & ~pop) begin
                count <= count + 1'b1;
            end else if (pop & ~push) begin
                count <= count - 1'b1;
            end
        end
    end
    // Storage write
    always @(posedge i_clk) begin
        if (push) begin
            buf_mem[wptr] <= i_data;
        end
    end
endmodule // b2ddr_fifo
`default_nettype wire

// File: core/b2ddr_port.v
// Function
// - Write data taken on both input clocks
// - Read words launched on both output clocks
// - Single-clock mode launches on input clocks
// - Data pins released when no read
// - Every transfer is exactly two words
// - Masks sampled with their data word
// - Masked lanes keep stored byte
// - One mask per nine-bit lane
// - One address bus for both directions
// - Storage split into two equal arrays
// - Address width includes burst start bit
// - Deselected port ignores address, no access
// - Direction high read, low write
// - Burst bit feeds one-bit linear counter
// - Accesses begin on positive input edge
// - New address only on alternate edges
`timescale 1ns/1ps
`include "b2ddr_defs.vh"
`default_nettype none
module b2ddr_port #(
    parameter DW = `B2DDR_DATA_W,
    parameter AW = `B2DDR_ADDR_W,
    parameter LW = `B2DDR_LANE_W,
    parameter LN = `B2DDR_LANES,
    parameter FD = `B2DDR_FIFO_DEPTH,
    parameter FPW = `B2DDR_FIFO_PW
) (
    // System clock and reset
    input wire i_clk,
    input wire i_rst_n,
    // Input clock pair and output clock pair (sampled)
    input wire i_kclk,
    input wire i_kclk_n,
    input wire i_cclk,
    input wire i_cclk_n,
    input wire i_single_clk,
    // Command pins
    input wire i_load_strobe_n,
    input wire i_rd_wr,
    input wire [AW-1:0] i_addr,
    input wire [LN-1:0] i_byte_write_mask_n,
    // Data pins, split
    input wire [DW-1:0] i_dq,
    output reg [DW-1:0] o_dq,
    output reg o_dq_oe
);
    // ----------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------
    localparam SW = 5 + AW + LN + DW;
    reg [SW-1:0] sync1;
    reg [SW-1:0] sync2;
    reg [3:0] clk_prev;
    wire k_s = sync2[SW-1];
    wire kn_s = sync2[SW-2];
    wire c_s = sync2[SW-3];
    wire cn_s = sync2[SW-4];
    wire single_s = sync2[SW-5];
    wire [AW-1:0] addr_s = sync2[LN+DW +: AW];
    wire [LN-1:0] mask_s = sync2[DW +: LN];
    wire [DW-1:0] dq_s = sync2[DW-1:0];
    reg ld_n_s1;
    reg ld_n_s;
    reg rw_s1;
    reg rw_s;
    // Two flops on every pin before any logic looks at it
    always @(posedge i_clk) begin
        sync1 <= {i_kclk, i_kclk_n, i_cclk, i_cclk_n, i_single_clk,
                  i_addr, i_byte_write_mask_n, i_dq};
        sync2 <= sync1;
        ld_n_s1 <= i_load_strobe_n;
        ld_n_s <= ld_n_s1;
        rw_s1 <= i_rd_wr;
        rw_s <= rw_s1;
    end

    // ----------------------------------------------------------
    // Edge detection on the sampled clocks
    // ----------------------------------------------------------
    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            // Live level in reset, so a high clock pin gives no false edge
            clk_prev <= {k_s, kn_s, c_s, cn_s};
        end else begin
            clk_prev <= {k_s, kn_s, c_s, cn_s};
        end
    end
    wire k_rise = k_s & ~clk_prev[3];
    wire kn_rise = kn_s & ~clk_prev[2];
    wire lp_rise = single_s ? k_rise : (c_s & ~clk_prev[1]);
    wire ln_rise = single_s ? kn_rise : (cn_s & ~clk_prev[0]);

    // ----------------------------------------------------------
    // Command capture and burst sequencing
    // ----------------------------------------------------------
    localparam ST_IDLE = 2'd0;
    localparam ST_WR2 = 2'd1;
    localparam ST_HOLD = 2'd2;
    reg [1:0] state;
    reg [1:0] next_state;
    reg [AW-1:0] base_addr;
    reg burst_bit;
    reg wr_go;
    reg [AW-1:0] wr_addr;
    reg [DW-1:0] wr_data;
    reg [LN-1:0] wr_mask_n;
    reg rd_go;
    reg rd_phase;
    reg [AW-1:0] rd_addr;
    // Incremented burst address: low bit toggles, linear wrap of one bit
    function [AW-1:0] burst_next;
        input [AW-1:0] a;
        begin
            burst_next = {a[AW-1:1], ~a[0]};
        end
    endfunction
    wire load_ok = k_rise & ~ld_n_s & (state != ST_WR2)
                   & (state != ST_HOLD);
    // Next state
    always @* begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (load_ok) begin
                    next_state = rw_s ? ST_HOLD : ST_WR2;
                end
            end
            ST_WR2: begin
                // Writes also skip the next K edge (alternate edges)
                if (kn_rise) begin
                    next_state = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (k_rise) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end
    // Capture on K, second write word on K-bar
    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            state <= ST_IDLE;
            base_addr <= {AW{1'b0}};
            burst_bit <= 1'b0;
            wr_go <= 1'b0;
            wr_addr <= {AW{1'b0}};
            wr_data <= {DW{1'b0}};
            wr_mask_n <= {LN{1'b1}};
            rd_go <= 1'b0;
            rd_addr <= {AW{1'b0}};
        end else begin
            state <= next_state;
            wr_go <= 1'b0;
            rd_go <= 1'b0;
            if (load_ok) begin
                base_addr <= addr_s;
                burst_bit <= addr_s[0];
                if (rw_s) begin
                    rd_go <= 1'b1;
                    rd_addr <= addr_s;
                end else begin
                    wr_go <= 1'b1;
                    wr_addr <= addr_s;
                    wr_data <= dq_s;
                    wr_mask_n <= mask_s;
                end
            end else if ((state == ST_WR2) & kn_rise) begin
                wr_go <= 1'b1;
                wr_addr <= burst_next(base_addr);
                wr_data <= dq_s;
                wr_mask_n <= mask_s;
            end
        end
    end

    // ----------------------------------------------------------
    // Two arrays, selected by the burst bit
    // ----------------------------------------------------------
    wire [DW-1:0] rd_even;
    wire [DW-1:0] rd_odd;
    wire [LN-1:0] lane_en = ~wr_mask_n;
    b2ddr_array #(.AW(AW-1), .DW(DW), .LW(LW), .LN(LN)) u_even (
        .i_clk(i_clk),
        .i_we(wr_go & ~wr_addr[0]),
        .i_lane_en(lane_en),
        .i_waddr(wr_addr[AW-1:1]),
        .i_wdata(wr_data),
        .i_re(rd_go),
        .i_raddr(rd_addr[AW-1:1]),
        .o_rdata(rd_even)
    );
    b2ddr_array #(.AW(AW-1), .DW(DW), .LW(LW), .LN(LN)) u_odd (
        .i_clk(i_clk),
        .i_we(wr_go & wr_addr[0]),
        .i_lane_en(lane_en),
        .i_waddr(wr_addr[AW-1:1]),
        .i_wdata(wr_data),
        .i_re(rd_go),
        .i_raddr(rd_addr[AW-1:1]),
        .o_rdata(rd_odd)
    );

    // ----------------------------------------------------------
    // Read words into the FIFO, first then burst partner
    // ----------------------------------------------------------
    reg rd_pend;
    reg rd_first_odd;
    reg push_phase;
    wire f_ready;
    wire f_valid;
    wire [DW-1:0] f_data;
    wire f_push = rd_pend;
    // Word order follows the loaded burst bit
    wire [DW-1:0] push_data = (push_phase ^ rd_first_odd) ? rd_odd : rd_even;
    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            rd_pend <= 1'b0;
            rd_first_odd <= 1'b0;
            push_phase <= 1'b0;
        end else if (rd_go) begin
            rd_pend <= 1'b1;
            rd_first_odd <= rd_addr[0];
            push_phase <= 1'b0;
        end else if (rd_pend & f_ready) begin
            // Holding until space keeps the pair whole under stall
            push_phase <= ~push_phase;
            rd_pend <= ~push_phase;
        end
    end
    b2ddr_fifo #(.DW(DW), .DEPTH(FD), .PW(FPW)) u_fifo (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_valid(f_push),
        .o_ready(f_ready),
        .i_data(push_data),
        .o_valid(f_valid),
        .i_ready(rd_phase ? ln_rise : lp_rise),
        .o_data(f_data)
    );

    // ----------------------------------------------------------
    // Launch on output-clock edges (K edges in single-clock mode), release pins when idle
    // ----------------------------------------------------------
    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_dq <= {DW{1'b0}};
            o_dq_oe <= 1'b0;
            rd_phase <= 1'b0;
        end else begin
            if (f_valid & (rd_phase ? ln_rise : lp_rise)) begin
                o_dq <= f_data;
                o_dq_oe <= 1'b1;
                rd_phase <= ~rd_phase;
            end else if (~f_valid & ~rd_phase & lp_rise) begin
                o_dq_oe <= 1'b0;
            end
        end
    end
endmodule // b2ddr_port
`default_nettype wire

// File: test/b2ddr_port_props.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------
// Port checker
// ----------------------------
module b2ddr_chk #(
    parameter DW = 36
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Clock pins and command
    input wire logic i_kclk,
    input wire logic i_kclk_n,
    input wire logic i_cclk,
    input wire logic i_cclk_n,
    input wire logic i_single_clk,
    input wire logic i_load_strobe_n,
    input wire logic i_rd_wr,
    // Read data
    input wire logic [DW-1:0] o_dq,
    input wire logic o_dq_oe
);
    logic pp, pn;
    logic [5:0] pos_age, any_age, rd_age, oe_cnt;
    wire sp = i_single_clk ? i_kclk : i_cclk;
    wire sn = i_single_clk ? i_kclk_n : i_cclk_n;
    // Ages saturate so that long idle gaps never wrap into a false pass
    always @(posedge i_clk) begin
        pp <= sp;
        pn <= sn;
        pos_age <= (sp && !pp) ? 6'h0 : pos_age + {5'h0, pos_age != 6'h3f};
        any_age <= ((sp && !pp) || (sn && !pn)) ? 6'h0
                   : any_age + {5'h0, any_age != 6'h3f};
        rd_age <= (!i_load_strobe_n && i_rd_wr) ? 6'h0
                  : rd_age + {5'h0, rd_age != 6'h3f};
        oe_cnt <= o_dq_oe ? oe_cnt + {5'h0, oe_cnt != 6'h3f} : 6'h0;
        if (!i_rst_n) begin
            pos_age <= 6'h3f;
            any_age <= 6'h3f;
            rd_age <= 6'h3f;
            oe_cnt <= 6'h0;
        end
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    a_reset_quiet: assert property (@(posedge i_clk) disable iff (1'b0)
        !i_rst_n |=> (!o_dq_oe && o_dq == '0)) else $error("outputs live in reset");
    a_oe_needs_read: assert property ($rose(o_dq_oe) |-> rd_age < 6'd40)
        else $error("drive without read");
    a_idle_released: assert property (rd_age == 6'h3f |-> !o_dq_oe)
        else $error("pins driven while idle");
    a_oe_bounded: assert property (oe_cnt <= 6'd12)
        else $error("drive longer than one pair");
    a_burst_two: assert property ($rose(o_dq_oe) |-> o_dq_oe [*6])
        else $error("burst cut short");
    a_rise_on_pos: assert property ($rose(o_dq_oe) |-> pos_age <= 6'd6)
        else $error("drive not on positive output edge");
    a_fall_on_pos: assert property ($fell(o_dq_oe) |-> pos_age <= 6'd6)
        else $error("release not on positive output edge");
    a_dq_on_edge: assert property (o_dq_oe && $past(o_dq_oe) && $changed(o_dq)
        |-> any_age <= 6'd6) else $error("word launched off edge");
    c_read: cover property ($rose(o_dq_oe));
    c_single: cover property ($rose(o_dq_oe) && i_single_clk);
    c_write: cover property (!i_load_strobe_n && !i_rd_wr);
endmodule // b2ddr_chk

bind b2ddr_port b2ddr_chk #(.DW(DW)) chk_u (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_kclk(i_kclk), .i_kclk_n(i_kclk_n), .i_cclk(i_cclk), .i_cclk_n(i_cclk_n),
    .i_single_clk(i_single_clk), .i_load_strobe_n(i_load_strobe_n),
    .i_rd_wr(i_rd_wr), .o_dq(o_dq), .o_dq_oe(o_dq_oe));
`default_nettype wire

// File: test/b2ddr_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------
// Memory controller model
// ----------------------------
module b2ddr_ctrl_model (
    // Bench clock and mode
    input wire logic i_clk,
    input wire logic i_single_clk,
    // Read data from the port
    input wire logic [35:0] i_dq,
    input wire logic i_dq_oe,
    // Clock pairs
    output logic o_kclk,
    output logic o_kclk_n,
    output logic o_cclk,
    output logic o_cclk_n,
    // Command and write data
    output logic o_load_strobe_n,
    output logic o_rd_wr,
    output logic [18:0] o_addr,
    output logic [3:0] o_mask_n,
    output logic [35:0] o_dq
);
    // Input clocks run free, offset from the bench clock edges
    initial begin
        o_load_strobe_n = 1'b1;
        o_rd_wr = 1'b0;
        o_addr = 19'h0_0000;
        o_mask_n = 4'hf;
        o_dq = 36'h0_0000_0000;
        o_kclk = 1'b0;
        o_kclk_n = 1'b1;
        #3;
        forever begin
            o_kclk = 1'b1;
            o_kclk_n = 1'b0;
            #32;
            o_kclk = 1'b0;
            o_kclk_n = 1'b1;
            #32;
        end
    end
    // Output clocks trail K by a quarter; parked low in single mode
    initial begin
        o_cclk = 1'b0;
        o_cclk_n = 1'b0;
        forever begin
            @(posedge o_kclk);
            #16;
            o_cclk = !i_single_clk;
            o_cclk_n = 1'b0;
            #32;
            o_cclk = 1'b0;
            o_cclk_n = !i_single_clk;
        end
    end
    // One two-word transfer; next call lands two K periods later at least
    task automatic xfer(input logic rw, input logic [18:0] a,
            input logic [35:0] d0, input logic [35:0] d1,
            input logic [3:0] m0, input logic [3:0] m1,
            output logic [35:0] r0, output logic [35:0] r1);
        int n;
        r0 = 'x;
        r1 = 'x;
        @(negedge o_kclk);
        #16;
        o_load_strobe_n = 1'b0;
        o_rd_wr = rw;
        o_addr = a;
        o_dq = d0;
        o_mask_n = m0;
        @(posedge o_kclk);
        #16;
        o_load_strobe_n = 1'b1;
        o_rd_wr = !rw;
        o_addr = ~a;
        o_dq = d1;
        o_mask_n = m1;
        #32;
        o_dq = ~d1;
        o_mask_n = ~m1;
        n = 0;
        while (rw && !i_dq_oe && n < 40) begin
            @(negedge i_clk);
            n++;
        end
        if (rw && i_dq_oe) begin
            r0 = i_dq;
            repeat (6) @(negedge i_clk);
            r1 = i_dq;
        end
    endtask
endmodule // b2ddr_ctrl_model
`default_nettype wire

// File: test/testbench.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------
// Port testbench
// ----------------------------
module testbench;
    logic i_clk, i_rst_n, single_clk;
    wire kc, kcn, cc, ccn, ld_n, rw, q_oe;
    wire [18:0] addr;
    wire [3:0] mask_n;
    wire [35:0] d, q;
    logic [35:0] r0, r1;
    int num_errors = 0;
    int num_checks = 0;
    int cyc = 0;
    b2ddr_port dut_u (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_kclk(kc),
        .i_kclk_n(kcn), .i_cclk(cc), .i_cclk_n(ccn), .i_single_clk(single_clk),
        .i_load_strobe_n(ld_n), .i_rd_wr(rw), .i_addr(addr),
        .i_byte_write_mask_n(mask_n), .i_dq(d), .o_dq(q), .o_dq_oe(q_oe));
    b2ddr_ctrl_model ctrl_u (.i_clk(i_clk), .i_single_clk(single_clk),
        .i_dq(q), .i_dq_oe(q_oe), .o_kclk(kc), .o_kclk_n(kcn), .o_cclk(cc),
        .o_cclk_n(ccn), .o_load_strobe_n(ld_n), .o_rd_wr(rw), .o_addr(addr),
        .o_mask_n(mask_n), .o_dq(d));
    task automatic chk(input string name, input logic [35:0] seen,
            input logic [35:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(input logic [18:0] a, input logic [35:0] d0,
            input logic [35:0] d1, input logic [3:0] m0, input logic [3:0] m1);
        ctrl_u.xfer(1'b0, a, d0, d1, m0, m1, r0, r1);
    endtask
    task automatic rd(input logic [18:0] a);
        ctrl_u.xfer(1'b1, a, 36'h0_0000_0000, 36'h0_0000_0000, 4'hf, 4'hf, r0, r1);
    endtask
    task automatic t_burst();
        wr(19'h0_0010, 36'h1_2345_6789, 36'h9_8765_4321, 4'h0, 4'h0);
        // Pins show read selected with load high: nothing may start
        repeat (24) @(posedge i_clk);
        chk("oe_after_write", {35'h0, q_oe}, 36'h0_0000_0000);
        rd(19'h0_0010);
        chk("rd_w0", r0, 36'h1_2345_6789);
        chk("rd_w1", r1, 36'h9_8765_4321);
        rd(19'h0_0011);
        chk("wrap_w0", r0, 36'h9_8765_4321);
        chk("wrap_w1", r1, 36'h1_2345_6789);
        wr(19'h4_0021, 36'ha_aaaa_5555, 36'h5_5555_aaaa, 4'h0, 4'h0);
        rd(19'h4_0020);
        chk("odd_w0", r0, 36'h5_5555_aaaa);
        chk("odd_w1", r1, 36'ha_aaaa_5555);
    endtask
    // After an all-lane fill, one lane enabled per word, a different lane in each word
    task automatic t_masks();
        logic [35:0] e0, e1, d0, d1;
        int l;
        e0 = 36'h0_0000_0000;
        e1 = 36'hf_ffff_ffff;
        wr(19'h2_0100, e0, e1, 4'h0, 4'h0);
        for (l = 0; l < 4; l++) begin
            d0 = 36'h9_abcd_ef12 + 36'(l);
            d1 = 36'h6_5432_10ed - 36'(l);
            wr(19'h2_0100, d0, d1, 4'(~(4'h1 << l)), 4'(~(4'h1 << (3 - l))));
            e0[l*9 +: 9] = d0[l*9 +: 9];
            e1[(3-l)*9 +: 9] = d1[(3-l)*9 +: 9];
            rd(19'h2_0100);
            chk("mask_w0", r0, e0);
            chk("mask_w1", r1, e1);
        end
    endtask
    task automatic t_single();
        @(posedge i_clk);
        single_clk <= 1'b1;
        rd(19'h0_0010);
        chk("single_w0", r0, 36'h1_2345_6789);
        chk("single_w1", r1, 36'h9_8765_4321);
        @(posedge i_clk);
        single_clk <= 1'b0;
    endtask
    task automatic complete_run();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // Bench clock
    initial begin
        i_clk = 1'b0;
        forever #4 i_clk = ~i_clk;
    end
    // Main sequence
    initial begin
        i_rst_n = 1'b0;
        single_clk = 1'b0;
        repeat (4) @(posedge i_clk);
        i_rst_n <= 1'b1;
        @(negedge i_clk);
        chk("rst_dq", q, 36'h0_0000_0000);
        chk("rst_oe", {35'h0, q_oe}, 36'h0_0000_0000);
        repeat (4) @(posedge i_clk);
        t_burst();
        t_masks();
        t_single();
        complete_run();
    end
    // Hang guard, well above the few hundred cycles the run needs
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            num_errors++;
            complete_run();
        end
    end
endmodule // testbench
`default_nettype wire
